/* src/sra_pkg.sv */
// Shared constants and types for the serial register access port.
// Assumes a 24-bit frame of one direction bit, a 7-bit address and
// 16 data bits, sent most significant bit first.
package sra_pkg;

    // Frame length and bit counter sizing.
    localparam int unsigned FRAME_BITS = 24;
    localparam int unsigned CNT_W      = 5;
    localparam logic [4:0]  FRAME_LEN  = 5'h18;
    // The counter stops one past a full frame so late edges are inert.
    localparam logic [4:0]  CNT_MAX    = 5'h19;
    localparam logic [4:0]  CNT_RST    = 5'h00;
    localparam logic [4:0]  CNT_ONE    = 5'h01;

    // Field layout of a frame.
    localparam int unsigned ADDR_W   = 7;
    localparam int unsigned DATA_W   = 16;
    localparam int unsigned RW_POS   = 23;
    localparam int unsigned ADDR_MSB = 22;
    localparam int unsigned ADDR_LSB = 16;
    localparam int unsigned DATA_MSB = 15;

    // Direction flag encodings.
    localparam logic RW_WRITE = 1'h0;
    localparam logic RW_READ  = 1'h1;

    // Reset values.
    localparam logic [23:0] WORD_RST = 24'h000000;
    localparam logic [6:0]  ADDR_RST = 7'h00;
    localparam logic [15:0] DATA_RST = 16'h0000;
    // The line idles high, so the remembered select level starts high.
    localparam logic        SEL_IDLE = 1'h1;

    // Control states of the register side.
    typedef enum logic [0:0] {
        SRA_IDLE,
        SRA_RDWAIT
    } sra_state_t;

    // Register-side state, held as one record.
    typedef struct packed {
        sra_state_t  state;
        logic        selPrev;
        logic        frameActive;
        logic        wrEn;
        logic        rdEn;
        logic        shortFrame;
        logic [6:0]  addr;
        logic [15:0] wrData;
        logic        rbValid;
        logic [23:0] rbWord;
    } sra_main_t;

    // Link-side state clocked on falling serial clock edges.
    typedef struct packed {
        logic [4:0]  cnt;
        logic [23:0] word;
    } sra_link_t;

endpackage : sra_pkg

/* src/sra_sync.sv */
// Two-flop level synchroniser, one bit lane per width step.
// Assumes the inputs are levels that stay put for several clocks.
`timescale 1ns/1ns
module sra_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk,
    input  wire logic         en,
    input  wire logic [W-1:0] d,
    output      logic [W-1:0] q
);

    // First stage; only the second stage reads it.
    logic [W-1:0] meta_r;

    ////////////////////////////////////////////////////////////////////////
    // Both stages hold while the enable is low.
    always_ff @(posedge clk) begin
        if (en) begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule : sra_sync

/* src/sra_port.sv */
// Serial register access port: a 24-bit framed serial target that turns
// each complete frame that ends while no read answer is awaited into a register write or read request.
// Assumes a register file on mclk that answers a read with regRdValid,
// and a serial clock that may stop or run freely between frames.
//
// Functional notes
// - select falling starts a new frame.
// - clock may be continuous or gated.
// - data sampled on falling clock edges.
// - select rising ends the access.
// - short frames are dropped, no access.
// - readback output starts disabled after reset.
// - only first 24 bits are used.
// - clock and data ignored while deselected.
// - output high impedance while deselected.
// - first byte is direction and address.
// - last 16 bits are the data.
// - bit 23 set means read, clear write.
// - bits 22-16 address, 15-0 write data.
// - next frame returns echo and read data.
`timescale 1ns/1ns
module sra_port
    import sra_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  rstn,
    input  wire logic                  ce,
    input  wire logic                  sclk,
    input  wire logic                  frameSelN,
    input  wire logic                  sdiPin,
    output      logic                  sdoPin,
    output      logic                  sdoEnN,
    input  wire logic                  readbackOutputEnable,
    input  wire logic                  readbackEdgeSelect,
    output      logic                  regWrEn,
    output      logic                  regRdEn,
    output      logic [sra_pkg::ADDR_W-1:0] regAddr,
    output      logic [sra_pkg::DATA_W-1:0] regWrData,
    input  wire logic [sra_pkg::DATA_W-1:0] regRdData,
    input  wire logic                  regRdValid,
    output      logic                  frameActive,
    output      logic                  shortFrame
);
    import sra_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations.

    sra_link_t   lnk_r;       // Falling-edge link state.
    sra_link_t   lnk_nxt;     // Its next value.
    logic        armed_r;     // Set while deselected; no edge yet seen.
    logic        sdoFall_r;   // Output bit when changing on falling edges.
    logic        sdoRise_r;   // Output bit when changing on rising edges.
    logic [4:0]  cntNow;      // Edges already taken in this frame.
    logic [4:0]  cntNext;     // Edges taken after the present edge.
    logic [1:0]  lnkSync;     // Settings seen from the link side.
    logic        rbEnS;       // Readback output enable, link side.
    logic        edgeSelS;    // Readback edge select, link side.
    logic        rbValidS;    // Readback word qualifier, link side.
    logic [23:0] rbLink;      // Word that the next frame shifts out.
    logic        selS;        // Select line seen from the register side.
    sra_main_t   st_r;        // Register-side state.
    sra_main_t   st_nxt;      // Its next value.
    logic        selRise;     // Frame end seen while idle.

    ////////////////////////////////////////////////////////////////////////
    // Link side.

    // Carry the readback settings into the link domain. A gated clock
    // only moves these flops during frames, so a changed setting becomes
    // safe from the third edge of a frame; set it one frame ahead of the
    // frame that relies on it.
    sra_sync #(
        .W (2)
    ) u_lnk_sync (
        .clk (sclk),
        .en  (1'h1),
        .d   ({readbackOutputEnable, readbackEdgeSelect}),
        .q   (lnkSync)
    );
    assign rbEnS    = lnkSync[1];
    assign edgeSelS = lnkSync[0];

    // The word qualifier is read raw: it only rises while the register
    // side waits after a read frame and only falls once a frame has ended,
    // so it stands still through the whole answer frame. A two-flop copy
    // on the gated link clock would arrive two edges too late and blank
    // the first echoed address bits.
    assign rbValidS = st_r.rbValid;

    // The word is held still by the register side from the moment its
    // qualifier rises, so it may be read raw once the qualifier is seen.
    assign rbLink = rbValidS ? st_r.rbWord : WORD_RST;

    // Count taken edges; the first edge after a deselect restarts at one,
    // so nothing depends on edges that came between frames.
    always_comb begin
        cntNow  = armed_r ? CNT_RST : lnk_r.cnt;
        cntNext = (cntNow == CNT_MAX) ? cntNow : cntNow + CNT_ONE;
        lnk_nxt = lnk_r;
        lnk_nxt.cnt = cntNext;
        // Shift in only the first 24 bits; later ones fall away.
        if (cntNow < FRAME_LEN) begin
            lnk_nxt.word = {lnk_r.word[22:0], sdiPin};
        end
    end

    // Falling-edge capture, gated by the select line so that a free
    // running clock between frames leaves the captured frame alone. The
    // word and count stay frozen after the frame for the register side.
    always_ff @(negedge sclk) begin
        if (!frameSelN) begin
            lnk_r <= lnk_nxt;
        end
    end

    // Frame start marker and falling-edge output bit. Deselect presets
    // both; the echoed direction of a read answer is always one, which
    // is why the first output bit can be a constant preset.
    always_ff @(negedge sclk or posedge frameSelN) begin
        if (frameSelN) begin
            armed_r   <= 1'h1;
            sdoFall_r <= RW_READ;
        end else begin
            armed_r   <= 1'h0;
            if (cntNext < FRAME_LEN) begin
                sdoFall_r <= rbLink[5'(RW_POS) - cntNext];
            end else begin
                sdoFall_r <= 1'h0;
            end
        end
    end

    // Rising-edge output bit: it moves half a clock after the falling
    // edge that counted the previous bit.
    always_ff @(posedge sclk or posedge frameSelN) begin
        if (frameSelN) begin
            sdoRise_r <= RW_READ;
        end else if (armed_r) begin
            sdoRise_r <= RW_READ;
        end else if (lnk_r.cnt < FRAME_LEN) begin
            sdoRise_r <= rbLink[5'(RW_POS) - lnk_r.cnt];
        end else begin
            sdoRise_r <= 1'h0;
        end
    end

    // Pick the edge on which the answer moves. Output enable follows the
    // select pin directly so the line releases at once on deselect. The
    // enable input comes from the register file, whose reset leaves it
    // off, so the port starts as a three-wire target.
    assign sdoPin = edgeSelS ? sdoRise_r : sdoFall_r;
    assign sdoEnN = frameSelN | ~rbEnS;

    ////////////////////////////////////////////////////////////////////////
    // Register side.

    // Select line into the register clock domain.
    sra_sync #(
        .W (1)
    ) u_sel_sync (
        .clk (mclk),
        .en  (ce),
        .d   (frameSelN),
        .q   (selS)
    );

    // A frame has ended once the synchronised select line rises.
    assign selRise = selS && !st_r.selPrev && (st_r.state == SRA_IDLE);

    // Decode a finished frame into one register request.
    always_comb begin
        st_nxt             = st_r;
        st_nxt.selPrev     = selS;
        st_nxt.frameActive = !selS;
        st_nxt.wrEn        = 1'h0;
        st_nxt.rdEn        = 1'h0;
        st_nxt.shortFrame  = 1'h0;
        case (st_r.state)
            SRA_IDLE: begin
                if (selRise) begin
                    // Any ended frame carried the pending answer out.
                    st_nxt.rbValid = 1'h0;
                    if (lnk_r.cnt < FRAME_LEN) begin
                        // Too few edges: drop it and flag shortFrame.
                        st_nxt.shortFrame = 1'h1;
                    end else begin
                        // Instruction byte then data field.
                        st_nxt.addr = lnk_r.word[ADDR_MSB:ADDR_LSB];
                        if (lnk_r.word[RW_POS] == RW_WRITE) begin
                            st_nxt.wrData = lnk_r.word[DATA_MSB:0];
                            st_nxt.wrEn   = 1'h1;
                        end else begin
                            st_nxt.rdEn  = 1'h1;
                            st_nxt.state = SRA_RDWAIT;
                        end
                    end
                end
            end
            SRA_RDWAIT: begin
                // Frames that end while waiting are not decoded; the
                // register file is expected to answer within a few clocks.
                if (regRdValid) begin
                    st_nxt.rbWord  = {RW_READ, st_r.addr, regRdData};
                    st_nxt.rbValid = 1'h1;
                    st_nxt.state   = SRA_IDLE;
                end
            end
            default: begin
                st_nxt.state = SRA_IDLE;
            end
        endcase
    end

    // Register the record; reset wins over the clock enable, which otherwise freezes every flop here.
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            st_r.state       <= SRA_IDLE;
            st_r.selPrev     <= SEL_IDLE;
            st_r.frameActive <= 1'h0;
            st_r.wrEn        <= 1'h0;
            st_r.rdEn        <= 1'h0;
            st_r.shortFrame  <= 1'h0;
            st_r.addr        <= ADDR_RST;
            st_r.wrData      <= DATA_RST;
            st_r.rbValid     <= 1'h0;
            st_r.rbWord      <= WORD_RST;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    // Requests leave straight from the record.
    assign regWrEn     = st_r.wrEn;
    assign regRdEn     = st_r.rdEn;
    assign regAddr     = st_r.addr;
    assign regWrData   = st_r.wrData;
    assign frameActive = st_r.frameActive;
    assign shortFrame  = st_r.shortFrame;

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    property p_short_drop;
        @(posedge mclk) disable iff (!rstn)
        ce && selRise && (lnk_r.cnt < FRAME_LEN)
            |=> shortFrame && !regWrEn && !regRdEn;
    endproperty
    a_short_drop: assert property (p_short_drop)
        else $error("short frame was not dropped");

    property p_write_commit;
        @(posedge mclk) disable iff (!rstn)
        ce && selRise && (lnk_r.cnt >= FRAME_LEN) && !lnk_r.word[23]
            |=> regWrEn && (regWrData == $past(lnk_r.word[15:0]))
                && (regAddr == $past(lnk_r.word[22:16]));
    endproperty
    a_write_commit: assert property (p_write_commit)
        else $error("full write frame did not commit its fields");

    property p_read_issue;
        @(posedge mclk) disable iff (!rstn)
        ce && selRise && (lnk_r.cnt >= FRAME_LEN) && lnk_r.word[23]
            |=> regRdEn && !regWrEn && (st_r.state == SRA_RDWAIT);
    endproperty
    a_read_issue: assert property (p_read_issue)
        else $error("read frame did not issue a read");

    property p_write_after_end;
        @(posedge mclk) disable iff (!rstn)
        regWrEn |-> $past(selS, 1) && !frameActive;
    endproperty
    a_write_after_end: assert property (p_write_after_end)
        else $error("write committed while selected");

    property p_read_echo;
        @(posedge mclk) disable iff (!rstn)
        ce && (st_r.state == SRA_RDWAIT) && regRdValid
            |=> st_r.rbValid && st_r.rbWord[23]
                && (st_r.rbWord[15:0] == $past(regRdData));
    endproperty
    a_read_echo: assert property (p_read_echo)
        else $error("readback word not loaded");

    property p_hiz_deselect;
        @(posedge mclk) disable iff (!rstn)
        frameSelN |-> sdoEnN;
    endproperty
    a_hiz_deselect: assert property (p_hiz_deselect)
        else $error("output driven while deselected");

    property p_late_bits;
        @(negedge sclk) disable iff (frameSelN)
        !armed_r && (lnk_r.cnt >= FRAME_LEN) |=> $stable(lnk_r.word);
    endproperty
    a_late_bits: assert property (p_late_bits)
        else $error("bits beyond the frame were taken");

    property p_sample_edge;
        @(negedge sclk) disable iff (frameSelN)
        (armed_r || (lnk_r.cnt < FRAME_LEN))
            |=> lnk_r.word[0] == $past(sdiPin);
    endproperty
    a_sample_edge: assert property (p_sample_edge)
        else $error("input bit not sampled on falling edge");

    property p_frame_restart;
        @(negedge sclk) disable iff (frameSelN)
        armed_r |=> (lnk_r.cnt == CNT_ONE) ##1 !armed_r;
    endproperty
    a_frame_restart: assert property (p_frame_restart)
        else $error("frame count did not restart");

    // Every answer opens with the echoed read direction, before any edge.
    property p_echo_first;
        @(negedge sclk) disable iff (frameSelN)
        armed_r |-> (sdoFall_r == RW_READ) && (sdoRise_r == RW_READ);
    endproperty
    a_echo_first: assert property (p_echo_first)
        else $error("first answer bit was not the read echo");

    // Any frame end drops the pending answer, so a stale word is never
    // shifted out after an unrelated access.
    property p_rb_clear;
        @(posedge mclk) disable iff (!rstn)
        ce && selRise |=> !st_r.rbValid;
    endproperty
    a_rb_clear: assert property (p_rb_clear)
        else $error("pending readback word survived a frame end");

    // A dropped frame must leave the request fields untouched.
    property p_short_keep;
        @(posedge mclk) disable iff (!rstn)
        shortFrame |-> $stable(regAddr) && $stable(regWrData);
    endproperty
    a_short_keep: assert property (p_short_keep)
        else $error("short frame changed the request fields");

    // The address only moves together with a request pulse.
    property p_addr_change;
        @(posedge mclk) disable iff (!rstn)
        $changed(regAddr) |-> regWrEn || regRdEn;
    endproperty
    a_addr_change: assert property (p_addr_change)
        else $error("address changed without a request");

endmodule : sra_port

/* sim/sra_ctrl_model.sv */
// Behavioural serial controller that faces the register access port.
// Assumes the bench calls xfer only while the select line idles high.
`timescale 1ns/1ns
module sra_ctrl_model (
    output      logic frameSelN,
    output      logic sclk,
    output      logic sdiPin,
    input  wire logic sdoPin,
    input  wire logic sdoEnN
);
    // A released output floats up to the pull-up level.
    wire sdoLine = sdoEnN ? 1'h1 : sdoPin;

    ////////////////////////////////////////////////////////////////////////
    // Idle levels: the gated link clock stands still between frames.
    // A short select pulse at power-up gives the port's start marker the
    // deselect edge it presets on; no clock edge falls inside it.
    initial begin
        frameSelN = 1'h0;
        sclk      = 1'h1;
        sdiPin    = 1'h0;
        #1;
        frameSelN = 1'h1;
    end

    // Sends n bits MSB first at 160 ns per bit and collects the answer.
    task automatic xfer(input logic [23:0] w, input int n,
                        output logic [23:0] rd, output logic en);
        rd = 24'h000000;
        en = 1'h1;
        frameSelN = 1'h0; // Falling select opens the frame.
        for (int i = 0; i < n; i++) begin
            sdiPin = (i < 24) ? w[23-i] : ~sdiPin;
            #80;
            if (i < 24) rd[23-i] = sdoLine;
            if (i == 2) en = sdoEnN;
            sclk = 1'h0; // The port samples data here.
            #80;
            sclk = 1'h1;
        end
        #80;
        frameSelN = 1'h1; // Rising select ends the access.
        sdiPin    = ~sdiPin; // Released data must not look held.
        #80;
    endtask : xfer

    // Toggles clock and data with the port deselected.
    task automatic noise(input int n);
        for (int i = 0; i < n; i++) begin
            #80 sclk = ~sclk;
            sdiPin = ~sdiPin;
        end
        sclk = 1'h1;
    endtask : noise
endmodule : sra_ctrl_model

/* sim/test_spi_register_access_port.sv */
// Self-checking bench for the serial register access port.
// Assumes the controller model owns the link pins; the bench plays the
// register file on mclk and answers each read three cycles later.
`timescale 1ns/1ns
module test_spi_register_access_port;
    import sra_pkg::*;
    logic        mclk = 1'h0;
    logic        rstn = 1'h0;
    logic        ce = 1'h1;
    logic        rbEn = 1'h0;
    logic        rbEdge = 1'h0;
    logic [15:0] regRdData = 16'h0000;
    logic        regRdValid = 1'h0;
    wire         sclk, frameSelN, sdiPin, sdoPin, sdoEnN;
    wire         regWrEn, regRdEn, frameActive, shortFrame;
    wire [6:0]   regAddr;
    wire [15:0]  regWrData;
    logic [15:0] mem [128]; // Register file image.
    logic [6:0]  rdAddr = 7'h00;
    logic [23:0] rdWord;
    logic        enSeen;
    int          rdDelay = 0, wrCount = 0, rdCount = 0, shCount = 0;
    int          actCount = 0;
    int          cycles = 0, errTotal = 0, testsRun = 0;

    always #10 mclk = ~mclk;

    sra_ctrl_model u_ctrl (.frameSelN(frameSelN), .sclk(sclk),
        .sdiPin(sdiPin), .sdoPin(sdoPin), .sdoEnN(sdoEnN));

    sra_port u_dut (.mclk(mclk), .rstn(rstn), .ce(ce), .sclk(sclk),
        .frameSelN(frameSelN), .sdiPin(sdiPin), .sdoPin(sdoPin),
        .sdoEnN(sdoEnN), .readbackOutputEnable(rbEn),
        .readbackEdgeSelect(rbEdge), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
        .regRdData(regRdData), .regRdValid(regRdValid),
        .frameActive(frameActive), .shortFrame(shortFrame));

    ////////////////////////////////////////////////////////////////////////
    // Register file stand-in, event counters and the hang limit.
    always @(posedge mclk) begin
        regRdValid <= 1'h0;
        if (shortFrame === 1'h1) shCount <= shCount + 1;
        if (frameActive === 1'h1) actCount <= actCount + 1;
        if (regWrEn === 1'h1) begin
            mem[regAddr] <= regWrData;
            wrCount      <= wrCount + 1;
        end
        if (regRdEn === 1'h1) begin
            rdCount <= rdCount + 1;
            rdAddr  <= regAddr;
            rdDelay <= 3;
        end else if (rdDelay == 1) begin
            regRdValid <= 1'h1;
            regRdData  <= mem[rdAddr];
            rdDelay    <= 0;
        end else if (rdDelay != 0) rdDelay <= rdDelay - 1;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errTotal++;
            finalReport();
        end
    end

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        testsRun++;
        if (seen !== exp) begin
            errTotal++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One frame, then time for the request and any read answer.
    task automatic frame(input logic [23:0] w, input int n);
        u_ctrl.xfer(w, n, rdWord, enSeen);
        repeat (14) @(posedge mclk);
    endtask : frame

    task automatic t_write();
        int w0 = wrCount;
        int a0 = actCount;
        frame({RW_WRITE, 7'h15, 16'hA5C3}, 24);
        check((actCount - a0) > 150, 1'h1);
        check(wrCount - w0, 1);
        check(regAddr, 7'h15);
        check(regWrData, 16'hA5C3);
        check(enSeen, 1'h1);
        check(sdoEnN, 1'h1);
    endtask : t_write

    // A frame one edge short must only raise shortFrame, with no write.
    task automatic t_short();
        int w0 = wrCount;
        int s0 = shCount;
        frame({RW_WRITE, 7'h22, 16'h1234}, 23);
        check(shCount - s0, 1);
        check(wrCount - w0, 0);
        check(regAddr, 7'h15);
    endtask : t_short

    task automatic t_long();
        int w0 = wrCount;
        frame({RW_WRITE, 7'h33, 16'h0F0F}, 30);
        check(wrCount - w0, 1);
        check({regAddr, regWrData}, {7'h33, 16'h0F0F});
    endtask : t_long

    // Deselected traffic is inert; the next frame still decodes.
    task automatic t_idle();
        int w0 = wrCount;
        int r0 = rdCount;
        u_ctrl.noise(20);
        repeat (8) @(posedge mclk);
        check(wrCount - w0 + rdCount - r0, 0);
        check(frameActive, 1'h0);
        frame({RW_WRITE, 7'h7F, 16'h8001}, 24);
        check({regAddr, regWrData}, {7'h7F, 16'h8001});
    endtask : t_idle

    task automatic t_read(input logic edgeSel);
        int r0 = rdCount;
        @(posedge mclk);
        rbEn   <= 1'h1;
        rbEdge <= edgeSel;
        frame(24'h000000, 4); // Short frame carries the new settings.
        frame({RW_READ, 7'h15, 16'hFFFF}, 24);
        check(rdCount - r0, 1);
        check(regAddr, 7'h15);
        frame({RW_READ, 7'h7F, 16'h0000}, 24);
        check(rdWord, {RW_READ, 7'h15, 16'hA5C3});
        check(enSeen, 1'h0);
        check(sdoEnN, 1'h1);
    endtask : t_read

    task automatic finalReport();
        if (errTotal == 0 && testsRun > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : finalReport

    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        repeat (12) @(posedge mclk);
        rstn <= 1'h1;
        repeat (5) @(posedge mclk);
        check({regWrEn, regRdEn, regAddr}, 9'h000);
        check(sdoEnN, 1'h1);
        t_write();
        t_short();
        t_long();
        t_idle();
        t_read(1'h0);
        t_read(1'h1);
        finalReport();
    end
endmodule : test_spi_register_access_port
